// ===== hdl/hmp_pkg.sv
package hmp_pkg;
    // host port modes, chosen by straps at reset release
    typedef enum logic [1:0] {
        HMP_MODE_NONE,
        HMP_MODE_MII,
        HMP_MODE_RMII,
        HMP_MODE_FIFO
    } hmp_mode_t;

    // strap codes, first strap is the most significant bit
    localparam logic [2:0] STRAP_MII            = 3'h1;
    localparam logic [2:0] STRAP_RMII           = 3'h2;
    localparam logic [2:0] STRAP_FIFO           = 3'h3;

    // data widths per mode
    localparam int         BYTE_W               = 8;
    localparam int         NIBBLE_W             = 4;
    localparam int         DIBIT_W              = 2;

    // fifo strobe must be low for at least three port clock periods
    localparam logic [1:0] STROBE_MIN_EDGES     = 2'h3;

    // interframe gap before receive-valid
    localparam real        REF_CLK_MHZ          = 100.0;
    localparam real        IFG_US               = 0.96;
    localparam int         IFG_CYCLES           = int'(IFG_US * REF_CLK_MHZ);
    localparam int         IFG_CNT_W            = 8;

    // ethernet preamble and start-of-frame delimiter, in bytes
    localparam logic [7:0] PREAMBLE_BYTE        = 8'h55;
    localparam logic [7:0] START_DELIM_BYTE     = 8'hD5;
    localparam logic [2:0] PREAMBLE_BYTES       = 3'h7;

    // serialiser last step index per byte, counted from zero
    localparam logic [1:0] STEPS_MII            = 2'h1;
    localparam logic [1:0] STEPS_RMII           = 2'h3;
    localparam logic [1:0] STEPS_FIFO           = 2'h0;

    // reset values
    localparam logic [7:0] BYTE_RESET           = 8'h00;
endpackage : hmp_pkg

// ===== hdl/hmp_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser, one per bit of the group
module hmp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    // stage_one is read by the second flop only
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    stage_one[i] <= 1'b0;
                    sync_out[i]  <= 1'b0;
                end else begin
                    stage_one[i] <= async_in[i];
                    sync_out[i]  <= stage_one[i];
                end
            end
        end
    endgenerate
endmodule : hmp_sync

// ===== hdl/hmp_host_port.sv
`timescale 1ns/1ps
// Overview of operation
// RQ1: transfers are half duplex, paced by carrier sense; host sends only when low.
// RQ2: host waits while a received frame is delivered until carrier sense drops.
// RQ3: back-to-back host frames spaced by one frame time plus interframe gap.
// RQ4: no collision output and no transmit-error input; failures handled inside.
// RQ5: one shared port clock serves both transmit and receive directions.
// RQ6: mii mode moves four bits per port clock at 2.5 or 25 MHz.
// RQ7: reduced mii moves two bits per port clock at 5 or 50 MHz.
// RQ8: fifo mode moves one byte per rising edge of low-active strobes.
// RQ9: fifo strobes shorter than three port clock periods are ignored.
// RQ10: straps 001 select mii, 010 reduced mii, 011 fifo.
// RQ11: mii transmit nibbles sampled synchronously from four data lines.
// RQ12: transmit enable frames each packet; data sampled while it is high.
// RQ13: carrier sense high while powerline traffic is present.
// RQ14: carrier sense held high for the whole transmit packet.
// RQ15: received frames start with preamble then start-of-frame delimiter.
// RQ16: receive valid high only while presented data is frame data.
// RQ17: receive error flags a decoding error in the delivered stream.
// RQ18: receive valid never asserted while transmit enable is high.
// RQ19: interframe gap of 0.96 us before raising receive valid.
// RQ20: reset holds carrier sense, valid and error low, drops partial frames.
// RQ21: straps sampled once at reset release, mode kept until next reset.
module hmp_host_port (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic [2:0] mode_straps,
    input  wire logic       host_port_clock,
    input  wire logic       host_tx_frame_enable,
    input  wire logic       fifo_write_strobe_n,
    input  wire logic       fifo_read_strobe_n,
    input  wire logic       fifo_select_n,
    input  wire logic [7:0] host_data_bus_in,
    output logic      [7:0] host_data_bus_out,
    output logic            host_data_bus_oe,
    output logic            host_carrier_sense,
    output logic            host_rx_valid,
    output logic            host_rx_error,
    input  wire logic       line_busy,
    output logic      [7:0] tx_byte,
    output logic            tx_byte_valid,
    output logic            tx_frame_end,
    input  wire logic       rx_pending,
    input  wire logic [7:0] rx_byte,
    input  wire logic       rx_byte_last,
    input  wire logic       rx_byte_error,
    output logic            rx_byte_taken
);
    typedef enum {
        HMP_IDLE,
        HMP_TX,
        HMP_RX_GAP,
        HMP_RX_PRE,
        HMP_RX_DATA
    } hmp_state_t;

    hmp_state_t            state;
    hmp_pkg::hmp_mode_t    mode;
    logic                  mode_taken;
    logic [1:0]            rel_pipe;
    logic [7:0]            data_s;
    logic [2:0]            straps_s;
    logic                  clk_s;
    logic                  txen_s;
    logic                  wr_s;
    logic                  rd_s;
    logic                  cs_s;
    logic                  clk_d;
    logic [1:0]            wr_low;
    logic [1:0]            rd_low;
    logic                  wr_d;
    logic                  rd_d;
    logic                  txen_d;
    logic [7:0]            shift;
    logic [1:0]            step;
    logic [7:0]            out_byte;
    logic [2:0]            pre_cnt;
    logic [hmp_pkg::IFG_CNT_W-1:0] gap_cnt;
    logic                  rx_last_seen;

    // every pin input crosses two flops before use
    hmp_sync #(.WIDTH(16)) u_sync (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .async_in ({host_data_bus_in, mode_straps, host_port_clock,
                    host_tx_frame_enable, fifo_write_strobe_n, fifo_read_strobe_n,
                    fifo_select_n}),
        .sync_out ({data_s, straps_s, clk_s, txen_s, wr_s, rd_s, cs_s})
    );

    // one shared port clock for both directions, rising edge found here [RQ5]
    wire clk_rise  = clk_s & ~clk_d;
    wire is_fifo   = (mode == hmp_pkg::HMP_MODE_FIFO);
    wire is_mii    = (mode == hmp_pkg::HMP_MODE_MII);
    wire is_rmii   = (mode == hmp_pkg::HMP_MODE_RMII);
    wire serial    = is_mii | is_rmii;
    wire [1:0] last_step = is_mii ? hmp_pkg::STEPS_MII : hmp_pkg::STEPS_RMII;
    // fifo strobes valid only after three low port clocks [RQ9]
    wire wr_ok     = (wr_low == hmp_pkg::STROBE_MIN_EDGES);
    wire rd_ok     = (rd_low == hmp_pkg::STROBE_MIN_EDGES);
    // byte moves on strobe rising edge [RQ8]
    wire wr_rise   = is_fifo & ~cs_s & wr_s & ~wr_d & wr_ok;
    wire rd_rise   = is_fifo & ~cs_s & rd_s & ~rd_d & rd_ok;
    // transmit framing: serial modes use enable, fifo starts on a write strobe and ends when select goes high [RQ12]
    wire tx_start  = serial ? (txen_s & clk_rise) : wr_rise;
    wire tx_end    = serial & ~txen_s & txen_d;
    // receive step advances on port clock or on an accepted read strobe [RQ15]
    wire rx_adv    = serial ? clk_rise : rd_rise;
    wire byte_done = is_fifo | (step == last_step);
    wire [7:0] next_shift = is_mii ? {data_s[3:0], shift[7:4]}
                                   : {data_s[1:0], shift[7:2]};

    // straps caught once, after the synchroniser has filled with pin values [RQ21]
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode       <= hmp_pkg::HMP_MODE_NONE;
            mode_taken <= 1'b0;
            rel_pipe   <= 2'h0;
        end else begin
            rel_pipe <= {rel_pipe[0], 1'b1};
            if (rel_pipe[1] && !mode_taken) begin
                mode_taken <= 1'b1;
                case (straps_s)                                 // [RQ10]
                    hmp_pkg::STRAP_MII:  mode <= hmp_pkg::HMP_MODE_MII;
                    hmp_pkg::STRAP_RMII: mode <= hmp_pkg::HMP_MODE_RMII;
                    hmp_pkg::STRAP_FIFO: mode <= hmp_pkg::HMP_MODE_FIFO;
                    default:             mode <= hmp_pkg::HMP_MODE_NONE;
                endcase
            end
        end
    end

    // edge history and strobe low-width counters
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_d  <= 1'b0;
            wr_d   <= 1'b1;
            rd_d   <= 1'b1;
            txen_d <= 1'b0;
            wr_low <= 2'h0;
            rd_low <= 2'h0;
        end else begin
            clk_d  <= clk_s;
            wr_d   <= wr_s;
            rd_d   <= rd_s;
            txen_d <= txen_s;
            if (wr_s)
                wr_low <= 2'h0;
            else if (clk_rise && !wr_ok)
                wr_low <= wr_low + 2'h1;                        // [RQ9]
            if (rd_s)
                rd_low <= 2'h0;
            else if (clk_rise && !rd_ok)
                rd_low <= rd_low + 2'h1;                        // [RQ9]
        end
    end

    // frame state machine; reset drops any partial frame [RQ20]
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state        <= HMP_IDLE;
            step         <= 2'h0;
            shift        <= hmp_pkg::BYTE_RESET;
            tx_byte      <= hmp_pkg::BYTE_RESET;
            tx_byte_valid <= 1'b0;
            tx_frame_end <= 1'b0;
            rx_byte_taken <= 1'b0;
            out_byte     <= hmp_pkg::BYTE_RESET;
            pre_cnt      <= 3'h0;
            gap_cnt      <= '0;
            rx_last_seen <= 1'b0;
            host_rx_valid <= 1'b0;
            host_rx_error <= 1'b0;
        end else begin
            tx_byte_valid <= 1'b0;
            tx_frame_end  <= 1'b0;
            rx_byte_taken <= 1'b0;
            case (state)
                HMP_IDLE: begin
                    step    <= 2'h0;
                    gap_cnt <= '0;
                    // a host frame has priority once started [RQ1]
                    if (tx_start) begin
                        state <= HMP_TX;
                        if (serial) begin
                            shift <= next_shift;                // [RQ11]
                            step  <= 2'h1;
                        end else begin
                            tx_byte       <= data_s;
                            tx_byte_valid <= 1'b1;
                        end
                    end else if (rx_pending && !txen_s) begin
                        state <= HMP_RX_GAP;
                    end
                end
                HMP_TX: begin
                    if (serial && txen_s && clk_rise) begin
                        // nibble or dibit sampled while enable is high [RQ12]
                        shift <= next_shift;
                        step  <= (step == last_step) ? 2'h0 : step + 2'h1;
                        if (step == last_step) begin            // [RQ6] [RQ7]
                            tx_byte       <= next_shift;
                            tx_byte_valid <= 1'b1;
                        end
                    end else if (wr_rise) begin
                        tx_byte       <= data_s;
                        tx_byte_valid <= 1'b1;
                    end
                    if (tx_end || (is_fifo && cs_s)) begin
                        state        <= HMP_IDLE;
                        tx_frame_end <= 1'b1;
                    end
                end
                HMP_RX_GAP: begin
                    // defer to a fresh transmit enable, then a full gap [RQ19]
                    if (txen_s)
                        gap_cnt <= '0;
                    else if (gap_cnt == hmp_pkg::IFG_CNT_W'(hmp_pkg::IFG_CYCLES - 1)) begin
                        state    <= HMP_RX_PRE;
                        pre_cnt  <= 3'h0;
                        step     <= 2'h0;
                        out_byte <= hmp_pkg::PREAMBLE_BYTE;
                    end else
                        gap_cnt <= gap_cnt + 1'b1;
                end
                HMP_RX_PRE, HMP_RX_DATA: begin
                    // valid rises just after a port clock edge in serial modes (at once in fifo mode), so the host's
                    // next sample still sees the first nibble [RQ16] [RQ18]
                    if (!host_rx_valid) begin
                        host_rx_valid <= clk_rise | is_fifo;
                    end else if (rx_adv) begin
                        step <= byte_done ? 2'h0 : step + 2'h1;
                        if (byte_done && state == HMP_RX_PRE) begin
                            // seven preamble bytes then the delimiter [RQ15]
                            pre_cnt  <= pre_cnt + 3'h1;
                            out_byte <= (pre_cnt == hmp_pkg::PREAMBLE_BYTES - 3'h1)
                                        ? hmp_pkg::START_DELIM_BYTE
                                        : hmp_pkg::PREAMBLE_BYTE;
                            if (pre_cnt == hmp_pkg::PREAMBLE_BYTES) begin
                                state         <= HMP_RX_DATA;
                                out_byte      <= rx_byte;
                                rx_byte_taken <= 1'b1;
                                rx_last_seen  <= rx_byte_last;
                                host_rx_error <= rx_byte_error; // [RQ17]
                            end
                        end else if (byte_done) begin
                            if (rx_last_seen) begin
                                state         <= HMP_IDLE;
                                host_rx_valid <= 1'b0;
                                host_rx_error <= 1'b0;
                            end else begin
                                out_byte      <= rx_byte;
                                rx_byte_taken <= 1'b1;
                                rx_last_seen  <= rx_byte_last;
                                host_rx_error <= rx_byte_error; // [RQ17]
                            end
                        end
                    end
                end
                default: state <= HMP_IDLE;
            endcase
        end
    end

    // presented receive data, low nibble or dibit first
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            host_data_bus_out <= hmp_pkg::BYTE_RESET;
        else if (is_mii)
            host_data_bus_out <= {4'h0, step[0] ? out_byte[7:4] : out_byte[3:0]};
        else if (is_rmii)
            host_data_bus_out <= {6'h00, out_byte[2*step +: 2]};
        else
            host_data_bus_out <= out_byte;
    end

    // bus driven only while a received frame is delivered
    assign host_data_bus_oe = host_rx_valid & (serial | (~cs_s & ~rd_s));

    // carrier sense: line traffic, transmit frame and receive seizure [RQ13] [RQ14] [RQ2]
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            host_carrier_sense <= 1'b0;                         // [RQ20]
        else
            host_carrier_sense <= line_busy | (state != HMP_IDLE) | tx_start;
    end

    // no collision or transmit-error pins exist on this port [RQ4]
endmodule : hmp_host_port

// ===== test/hmp_host_port_asserts.sv
`timescale 1ns/1ps
// relations between host pins and the internal side of the port
module hmp_host_port_asserts (
    input logic ref_clk,
    input logic reset_n,
    input logic host_tx_frame_enable,
    input logic line_busy,
    input logic host_carrier_sense,
    input logic host_rx_valid,
    input logic host_rx_error,
    input logic tx_frame_end
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // status pins quiet while reset is held
    a_reset_quiet: assert property (disable iff (1'b0)
        !reset_n |-> !host_carrier_sense && !host_rx_valid && !host_rx_error)
        else $error("status pins high in reset");
    a_valid_has_cs: assert property (host_rx_valid |-> host_carrier_sense)
        else $error("receive valid without carrier sense");
    a_no_rx_on_tx: assert property (host_tx_frame_enable |-> !host_rx_valid)
        else $error("receive valid while host transmits");
    // carrier sense must already be high 95 cycles before valid rises
    a_gap_before_valid: assert property ($rose(host_rx_valid) |->
        $past(host_carrier_sense, 95)) else $error("valid raised without gap");
    a_cs_on_txen: assert property ($rose(host_tx_frame_enable) |->
        ##[1:40] host_carrier_sense) else $error("no carrier sense after tx start");
    a_cs_holds_tx: assert property (host_tx_frame_enable && host_carrier_sense
        |=> host_carrier_sense) else $error("carrier sense dropped in frame");
    a_busy_raises_cs: assert property ($rose(line_busy) |->
        ##[1:3] host_carrier_sense) else $error("line traffic without carrier sense");
    a_cs_drop_idle: assert property ($fell(host_carrier_sense) |->
        !$past(line_busy)) else $error("carrier sense fell with line busy");
    a_error_in_frame: assert property (host_rx_error |-> host_rx_valid)
        else $error("receive error outside frame");
    a_end_after_txen: assert property (tx_frame_end |-> !host_tx_frame_enable)
        else $error("frame end while enable high");
endmodule : hmp_host_port_asserts

bind hmp_host_port hmp_host_port_asserts i_hmp_host_port_asserts (.ref_clk, .reset_n,
    .host_tx_frame_enable, .line_busy, .host_carrier_sense, .host_rx_valid,
    .host_rx_error, .tx_frame_end);

// ===== test/hmp_mac_model.sv
`timescale 1ns/1ps
// external mac or fifo host with a free running port clock
module hmp_mac_model (
    output logic       host_port_clock,
    output logic       host_tx_frame_enable,
    output logic [7:0] host_data_bus_in,
    output logic       fifo_write_strobe_n,
    output logic       fifo_read_strobe_n,
    output logic       fifo_select_n,
    input  logic       host_carrier_sense
);
    // idle levels; this host never reads through the fifo
    initial begin
        host_port_clock      = 1'b0;
        host_tx_frame_enable = 1'b0;
        host_data_bus_in     = 8'h00;
        fifo_write_strobe_n  = 1'b1;
        fifo_read_strobe_n   = 1'b1;
        fifo_select_n        = 1'b1;
    end
    always #80 host_port_clock = ~host_port_clock; // 160 ns period
    // wait for carrier sense low, then eight port clocks (1.28 us, longer than one interframe gap)
    task automatic wait_clear();
        int i;
        for (i = 0; i < 400 && host_carrier_sense !== 1'b0; i++) @(posedge host_port_clock);
        repeat (8) @(posedge host_port_clock);
    endtask : wait_clear
    // one frame of four bytes, low nibble or dibit first, w bits per clock
    task automatic send_frame(input logic [7:0] b [4], input int w);
        wait_clear();
        foreach (b[i]) for (int k = 0; k < 8; k += w) begin
            @(negedge host_port_clock);
            host_tx_frame_enable <= 1'b1;
            host_data_bus_in     <= 8'((b[i] >> k) & ((1 << w) - 1));
        end
        @(negedge host_port_clock);
        host_tx_frame_enable <= 1'b0;
        host_data_bus_in     <= ~host_data_bus_in; // released lines do not keep the value
    endtask : send_frame
    // one fifo write with the strobe low for p port clocks
    task automatic fifo_write(input logic [7:0] d, input int p, input bit last);
        @(negedge host_port_clock);
        fifo_select_n       <= 1'b0;
        fifo_write_strobe_n <= 1'b0;
        host_data_bus_in    <= d;
        repeat (p) @(posedge host_port_clock);
        @(negedge host_port_clock);
        fifo_write_strobe_n <= 1'b1;
        @(negedge host_port_clock);
        host_data_bus_in    <= ~d;
        fifo_select_n       <= last;
    endtask : fifo_write
endmodule : hmp_mac_model

// ===== test/hmp_host_port_tb_top.sv
`timescale 1ns/1ps
module hmp_host_port_tb_top;
    logic       ref_clk, reset_n, line_busy, rx_pending, rx_byte_last, rx_byte_error;
    logic       host_port_clock, host_tx_frame_enable, fifo_write_strobe_n;
    logic       fifo_read_strobe_n, fifo_select_n, host_data_bus_oe, host_carrier_sense;
    logic       host_rx_valid, host_rx_error, tx_byte_valid, tx_frame_end, rx_byte_taken;
    logic [2:0] mode_straps;
    logic [1:0] ridx;
    logic [7:0] host_data_bus_in, host_data_bus_out, tx_byte, rx_byte;
    logic [7:0] rx_mem [4];
    logic [7:0] d [3];
    logic [7:0] got_q [$];
    logic [3:0] nib_q [$];
    int         err_count, n_tests, ends, i, g;
    int         seed = 32'h7f1e;
    bit         err_seen;

    hmp_host_port i_hmp_host_port (.ref_clk, .reset_n, .mode_straps, .host_port_clock,
        .host_tx_frame_enable, .fifo_write_strobe_n, .fifo_read_strobe_n, .fifo_select_n,
        .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe, .host_carrier_sense,
        .host_rx_valid, .host_rx_error, .line_busy, .tx_byte, .tx_byte_valid, .tx_frame_end,
        .rx_pending, .rx_byte, .rx_byte_last, .rx_byte_error, .rx_byte_taken);
    hmp_mac_model i_hmp_mac_model (.host_port_clock, .host_tx_frame_enable, .host_data_bus_in,
        .fifo_write_strobe_n, .fifo_read_strobe_n, .fifo_select_n, .host_carrier_sense);

    always #5 ref_clk = ~ref_clk;
    // receive byte source: third byte flagged bad, fourth is last
    assign rx_byte       = rx_mem[ridx];
    assign rx_byte_last  = (ridx == 2'h3);
    assign rx_byte_error = (ridx == 2'h2);
    // collect assembled bytes, frame ends, errors; advance the receive source
    always @(posedge ref_clk) begin
        if (tx_byte_valid === 1'b1) got_q.push_back(tx_byte);
        if (tx_frame_end === 1'b1) ends++;
        if (host_rx_error === 1'b1) err_seen = 1'b1;
        if (rx_byte_taken === 1'b1) ridx <= ridx + 2'h1;
        if (rx_byte_taken === 1'b1 && rx_byte_last) rx_pending <= 1'b0;
    end
    // receive nibbles as the host sees them on its clock
    always @(posedge host_port_clock) if (host_rx_valid === 1'b1) begin
        nib_q.push_back(host_data_bus_out[3:0]);
        chk("bus drive", 16'h1, 16'(host_data_bus_oe));
    end

    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] v);
        n_tests++;
        if (v !== e) begin
            err_count++;
            $display("Error %s expected %0h got %0h", s, e, v);
        end
    endtask : chk
    // expected receive nibble: preamble, delimiter, then payload low nibble first
    function automatic logic [3:0] exp_nib(input int n);
        logic [7:0] b;
        b = (n < 14) ? hmp_pkg::PREAMBLE_BYTE : (n < 16) ? hmp_pkg::START_DELIM_BYTE
            : rx_mem[n / 2 - 8];
        return n[0] ? b[7:4] : b[3:0];
    endfunction : exp_nib
    task automatic do_reset(input logic [2:0] s);
        reset_n     <= 1'b0;
        mode_straps <= s;
        repeat (2) @(posedge ref_clk);
        chk("reset quiet", 16'h0, 16'({host_carrier_sense, host_rx_valid, host_rx_error}));
        reset_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        mode_straps <= 3'h7; // later strap moves must not change the mode
        got_q.delete();
        nib_q.delete();
        ends     = 0;
        err_seen = 1'b0;
    endtask : do_reset
    // two back-to-back frames in a serial mode of w bits per clock
    task automatic run_tx(input logic [2:0] s, input int w);
        logic [7:0] b [4];
        logic [7:0] e [$];
        do_reset(s);
        for (int f = 0; f < 2; f++) begin
            foreach (b[k]) b[k] = $random(seed);
            foreach (b[k]) e.push_back(b[k]);
            i_hmp_mac_model.send_frame(b, w);
        end
        i_hmp_mac_model.wait_clear();
        chk("tx count", 16'(e.size()), 16'(got_q.size()));
        foreach (e[k]) chk("tx byte", 16'(e[k]), 16'(got_q[k]));
        chk("frame ends", 16'h2, 16'(ends));
    endtask : run_tx
    task automatic summarize();
        if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize

    initial begin
        #200000;
        err_count++;
        summarize();
    end
    initial begin
        ref_clk     = 1'b0;
        reset_n     = 1'b0;
        mode_straps = hmp_pkg::STRAP_MII;
        line_busy   = 1'b0;
        rx_pending  = 1'b0;
        ridx        = 2'h0;
        foreach (rx_mem[k]) rx_mem[k] = 8'h00;
        run_tx(hmp_pkg::STRAP_MII, 4);
        run_tx(hmp_pkg::STRAP_RMII, 2);
        // fifo: minimum strobe taken, one period short ignored
        do_reset(hmp_pkg::STRAP_FIFO);
        foreach (d[k]) d[k] = $random(seed);
        i_hmp_mac_model.fifo_write(d[0], 3, 1'b0);
        i_hmp_mac_model.fifo_write(d[1], 2, 1'b0);
        i_hmp_mac_model.fifo_write(d[2], 3, 1'b1);
        repeat (40) @(posedge ref_clk);
        chk("fifo count", 16'h2, 16'(got_q.size()));
        chk("fifo byte", 16'(d[0]), 16'(got_q[0]));
        chk("fifo byte", 16'(d[2]), 16'(got_q[1]));
        chk("fifo end", 16'h1, 16'(ends));
        // powerline traffic raises carrier sense
        line_busy <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("busy cs", 16'h1, 16'(host_carrier_sense));
        line_busy <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk("idle cs", 16'h0, 16'(host_carrier_sense));
        // receive one frame in mii mode
        do_reset(hmp_pkg::STRAP_MII);
        foreach (rx_mem[k]) rx_mem[k] <= $random(seed);
        rx_pending <= 1'b1;
        for (i = 0; i < 40 && host_carrier_sense !== 1'b1; i++) @(posedge ref_clk);
        for (g = 0; g < 400 && host_rx_valid !== 1'b1; g++) @(posedge ref_clk);
        chk("gap", 16'h1, 16'(g >= 95 && g < 400));
        for (i = 0; i < 4000 && host_rx_valid === 1'b1; i++) @(posedge ref_clk);
        repeat (2) @(posedge host_port_clock);
        chk("rx nibbles", 16'h18, 16'(nib_q.size()));
        foreach (nib_q[k]) chk("rx nibble", 16'(exp_nib(k)), 16'(nib_q[k]));
        chk("rx error", 16'h1, 16'(err_seen));
        summarize();
    end
endmodule : hmp_host_port_tb_top
